// [sdd_cfg.svh]
// constants for the split-channel dma redirect bridge
//
// Contract
// - distributed-channel host read is retried, then the PCI bus is requested.
// - with the grant, I/O reads go to peripherals and the local core.
// - peripheral read data is merged with local core contents (code merges status reads only; other reads return the peripheral data alone).
// - the repeated read completes with the merged value.
// - distributed write is retried, bus acquired, I/O writes issued.
// - written values derive from host data; repeated write completes normally.
// - peripheral address: bits 31:16 zero, bits 15:6 from base pointer.
// - base pointer at 92h for channels 0-3, 94h for 5-7.
// - address bits 5:4 are the channel number modulo four.
// - address low byte index 0h, high byte index 1h, by flip-flop.
// - page register accesses map to index 2h regardless of flip-flop.
// - word count low byte index 4h, high byte index 5h.
// - command/status 8h, request 9h, mode Bh, master clear Dh, all-masks Fh.
// - single mask writes channel's index Fh with bit 0 from data bit 2.
// - clear-mask writes 0h to index Fh of each distributed channel.
// - other DMA register accesses are retried while a sequence runs.
// - distributed channels are selected by configuration space bits.
// - channel 4 is never distributed.
`ifndef SDD_CFG_SVH
`define SDD_CFG_SVH

`define SDD_CFG_BASE_LO     8'h92
`define SDD_CFG_BASE_HI     8'h94
`define SDD_CFG_RESET       16'h0000
`define SDD_BASE_MSB        15
`define SDD_BASE_LSB        6
`define SDD_EN_LO_MSB       3
`define SDD_EN_HI_MSB       3
`define SDD_EN_HI_LSB       1

`define SDD_IDX_ADDR_LO     4'h0
`define SDD_IDX_ADDR_HI     4'h1
`define SDD_IDX_PAGE        4'h2
`define SDD_IDX_COUNT_LO    4'h4
`define SDD_IDX_COUNT_HI    4'h5
`define SDD_IDX_CMD         4'h8
`define SDD_IDX_REQ         4'h9
`define SDD_IDX_MODE        4'hB
`define SDD_IDX_MCLR        4'hD
`define SDD_IDX_ALLMASK     4'hF

`define SDD_SMASK_DATA_BIT  2
`define SDD_STATUS_MASK     8'h11

`endif

// [sdd_pkg.sv]
// types shared by the split-channel dma redirect bridge
package sdd_pkg;
  typedef enum logic [3:0] {
    SDD_K_ADDR, SDD_K_COUNT, SDD_K_PAGE, SDD_K_CMD, SDD_K_REQ, SDD_K_MODE,
    SDD_K_MCLR, SDD_K_ALLMASK, SDD_K_SMASK, SDD_K_CLRMASK, SDD_K_LOCAL
  } sdd_kind_t;

  typedef enum {
    SDD_IDLE, SDD_DIRECT, SDD_FINISH, SDD_BUS_REQ, SDD_PERIPH, SDD_LOCAL, SDD_READY
  } sdd_state_t;
endpackage

// [sdd_addr.sv]
// peripheral I/O address builder
`include "sdd_cfg.svh"
module sdd_addr
  import sdd_pkg::*;
(
  input  wire logic [15:0] base_lo_in,
  input  wire logic [15:0] base_hi_in,
  input  wire logic        ctl_hi_in,
  input  wire logic [1:0]  slot_in,
  input  wire logic [3:0]  index_in,
  output logic      [31:0] addr_out
);
  logic [15:0] base;

  assign base = ctl_hi_in ? base_hi_in : base_lo_in;
  assign addr_out = {16'h0000,
                     base[`SDD_BASE_MSB:`SDD_BASE_LSB],
                     slot_in,
                     index_in};
endmodule

// [sdd_bridge.sv]
// split-channel dma redirect bridge: retry, peripheral cycles, merge, completion
`include "sdd_cfg.svh"
module sdd_bridge
  import sdd_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic        ce_in,
  // host target side, legacy dma register accesses
  input  wire logic        tgt_req_in,
  input  wire logic        tgt_write_in,
  input  wire logic [7:0]  tgt_addr_in,
  input  wire logic [7:0]  tgt_wdata_in,
  output logic      [7:0]  tgt_rdata_out,
  output logic             tgt_done_out,
  output logic             tgt_retry_out,
  // configuration space
  input  wire logic        cfg_wr_in,
  input  wire logic        cfg_rd_in,
  input  wire logic [7:0]  cfg_addr_in,
  input  wire logic [15:0] cfg_wdata_in,
  output logic      [15:0] cfg_rdata_out,
  // local dma core
  output logic             core_req_out,
  output logic             core_write_out,
  output logic      [7:0]  core_addr_out,
  output logic      [7:0]  core_wdata_out,
  input  wire logic [7:0]  core_rdata_in,
  input  wire logic        core_ack_in,
  input  wire logic        core_ff_in,
  // PCI master side
  output logic             pci_req_out,
  input  wire logic        pci_gnt_in,
  output logic             io_req_out,
  output logic             io_write_out,
  output logic      [31:0] io_addr_out,
  output logic      [7:0]  io_wdata_out,
  input  wire logic [7:0]  io_rdata_in,
  input  wire logic        io_ack_in
);
  sdd_state_t  state;
  logic [15:0] base_lo;
  logic [15:0] base_hi;
  logic [7:0]  dist_vec;

  sdd_kind_t   dec_kind;
  logic [2:0]  dec_chan;
  logic        dec_ctl;
  logic [3:0]  dec_mask;
  logic        dec_dist;

  logic        pend_write;
  logic [7:0]  pend_addr;
  logic [7:0]  pend_wdata;
  sdd_kind_t   pend_kind;
  logic        pend_ctl;
  logic        pend_ff;
  logic [3:0]  pend_mask;
  logic [1:0]  cur_slot;
  logic [7:0]  merge_acc;
  logic [7:0]  rdata;

  logic [3:0]  launch_mask;
  logic [1:0]  launch_slot;
  logic [3:0]  launch_index;
  logic [7:0]  launch_wdata;
  logic [31:0] launch_addr;
  logic        match;
  logic        take;
  logic [3:0]  slots_all;

  function automatic logic [1:0] sdd_lowest(input logic [3:0] m);
    logic [1:0] r;
    r = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (m[i]) begin
        r = i[1:0];
      end
    end
    return r;
  endfunction

  // channel 4 slot forced off
  assign dist_vec = {base_hi[`SDD_EN_HI_MSB:`SDD_EN_HI_LSB], 1'b0,
                     base_lo[`SDD_EN_LO_MSB:0]};

  // slots that are distributed for the captured controller
  assign slots_all = pend_ctl ? dist_vec[7:4] : dist_vec[3:0];

  // configuration registers
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      base_lo <= `SDD_CFG_RESET;
      base_hi <= `SDD_CFG_RESET;
    end else if (ce_in && cfg_wr_in) begin
      if (cfg_addr_in == `SDD_CFG_BASE_LO) begin
        base_lo <= cfg_wdata_in;
      end
      if (cfg_addr_in == `SDD_CFG_BASE_HI) begin
        base_hi <= cfg_wdata_in;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      cfg_rdata_out <= 16'h0000;
    end else if (ce_in && cfg_rd_in) begin
      case (cfg_addr_in)
        `SDD_CFG_BASE_LO: cfg_rdata_out <= base_lo;
        `SDD_CFG_BASE_HI: cfg_rdata_out <= base_hi;
        default:          cfg_rdata_out <= 16'h0000;
      endcase
    end
  end

  // legacy address decode
  always_comb begin
    dec_kind = SDD_K_LOCAL;
    dec_chan = 3'h0;
    case (tgt_addr_in) inside
      [8'h00:8'h07]: begin
        dec_kind = tgt_addr_in[0] ? SDD_K_COUNT : SDD_K_ADDR;
        dec_chan = {1'b0, tgt_addr_in[2:1]};
      end
      [8'hC0:8'hCF]: begin
        dec_kind = tgt_addr_in[1] ? SDD_K_COUNT : SDD_K_ADDR;
        dec_chan = {1'b1, tgt_addr_in[3:2]};
      end
      8'h87: begin dec_kind = SDD_K_PAGE; dec_chan = 3'h0; end
      8'h83: begin dec_kind = SDD_K_PAGE; dec_chan = 3'h1; end
      8'h81: begin dec_kind = SDD_K_PAGE; dec_chan = 3'h2; end
      8'h82: begin dec_kind = SDD_K_PAGE; dec_chan = 3'h3; end
      8'h8B: begin dec_kind = SDD_K_PAGE; dec_chan = 3'h5; end
      8'h89: begin dec_kind = SDD_K_PAGE; dec_chan = 3'h6; end
      8'h8A: begin dec_kind = SDD_K_PAGE; dec_chan = 3'h7; end
      8'h08, 8'hD0: begin dec_kind = SDD_K_CMD; end
      8'h09, 8'hD2: begin dec_kind = SDD_K_REQ; end
      8'h0A, 8'hD4: begin dec_kind = SDD_K_SMASK; end
      8'h0B, 8'hD6: begin dec_kind = SDD_K_MODE; end
      8'h0D, 8'hDA: begin dec_kind = SDD_K_MCLR; end
      8'h0E, 8'hDC: begin dec_kind = SDD_K_CLRMASK; end
      8'h0F, 8'hDE: begin dec_kind = SDD_K_ALLMASK; end
      default: begin dec_kind = SDD_K_LOCAL; end
    endcase
  end

  assign dec_ctl = (dec_kind == SDD_K_ADDR || dec_kind == SDD_K_COUNT ||
                    dec_kind == SDD_K_PAGE) ? dec_chan[2] : tgt_addr_in[7];

  // which channel slots of the controller take a peripheral cycle
  always_comb begin
    dec_mask = 4'h0;
    case (dec_kind)
      SDD_K_ADDR, SDD_K_COUNT, SDD_K_PAGE: begin
        dec_mask[dec_chan[1:0]] = dist_vec[dec_chan];
      end
      SDD_K_CMD: begin
        dec_mask = dec_ctl ? dist_vec[7:4] : dist_vec[3:0];
      end
      SDD_K_REQ, SDD_K_MODE, SDD_K_SMASK: begin
        if (tgt_write_in) begin
          dec_mask[tgt_wdata_in[1:0]] = dist_vec[{dec_ctl, tgt_wdata_in[1:0]}];
        end
      end
      SDD_K_MCLR, SDD_K_ALLMASK, SDD_K_CLRMASK: begin
        if (tgt_write_in) begin
          dec_mask = dec_ctl ? dist_vec[7:4] : dist_vec[3:0];
        end
      end
      default: dec_mask = 4'h0;
    endcase
  end

  assign dec_dist = |dec_mask;
  assign match = (tgt_addr_in == pend_addr) && (tgt_write_in == pend_write);
  assign take = ce_in && tgt_req_in && (state == SDD_IDLE);

  // host answers
  always_comb begin
    tgt_retry_out = 1'b0;
    tgt_done_out = 1'b0;
    if (ce_in && tgt_req_in) begin
      case (state)
        SDD_IDLE:   tgt_retry_out = dec_dist;
        SDD_FINISH: tgt_done_out = 1'b1;
        SDD_READY: begin
          tgt_done_out = match;
          tgt_retry_out = !match;
        end
        SDD_BUS_REQ, SDD_PERIPH, SDD_LOCAL: tgt_retry_out = 1'b1;
        default: begin
          tgt_retry_out = 1'b0;
          tgt_done_out = 1'b0;
        end
      endcase
    end
  end

  assign tgt_rdata_out = rdata;

  // next peripheral cycle
  assign launch_mask = (state == SDD_PERIPH) ? (pend_mask & ~(4'h1 << cur_slot)) : pend_mask;
  assign launch_slot = sdd_lowest(launch_mask);

  always_comb begin
    case (pend_kind)
      SDD_K_ADDR:    launch_index = pend_ff ? `SDD_IDX_ADDR_HI : `SDD_IDX_ADDR_LO;
      SDD_K_COUNT:   launch_index = pend_ff ? `SDD_IDX_COUNT_HI : `SDD_IDX_COUNT_LO;
      SDD_K_PAGE:    launch_index = `SDD_IDX_PAGE;
      SDD_K_CMD:     launch_index = `SDD_IDX_CMD;
      SDD_K_REQ:     launch_index = `SDD_IDX_REQ;
      SDD_K_MODE:    launch_index = `SDD_IDX_MODE;
      SDD_K_MCLR:    launch_index = `SDD_IDX_MCLR;
      default:       launch_index = `SDD_IDX_ALLMASK;
    endcase
  end

  // peripheral write data from the host's original data, zero for clear-mask
  always_comb begin
    case (pend_kind)
      SDD_K_ALLMASK: launch_wdata = {7'h00, pend_wdata[launch_slot]};
      SDD_K_SMASK:   launch_wdata = {7'h00, pend_wdata[`SDD_SMASK_DATA_BIT]};
      SDD_K_CLRMASK: launch_wdata = 8'h00;
      default:       launch_wdata = pend_wdata;
    endcase
  end

  sdd_addr u_addr (
    .base_lo_in (base_lo),
    .base_hi_in (base_hi),
    .ctl_hi_in  (pend_ctl),
    .slot_in    (launch_slot),
    .index_in   (launch_index),
    .addr_out   (launch_addr)
  );

  // sequencer
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state <= SDD_IDLE;
    end else if (ce_in) begin
      case (state)
        SDD_IDLE: begin
          if (tgt_req_in) begin
            state <= dec_dist ? SDD_BUS_REQ : SDD_DIRECT;
          end
        end
        SDD_DIRECT: begin
          if (core_ack_in) begin
            state <= SDD_FINISH;
          end
        end
        SDD_FINISH: begin
          if (tgt_req_in) begin
            state <= SDD_IDLE;
          end
        end
        SDD_BUS_REQ: begin
          if (pci_gnt_in) begin
            state <= SDD_PERIPH;
          end
        end
        SDD_PERIPH: begin
          if (io_ack_in && launch_mask == 4'h0) begin
            state <= SDD_LOCAL;
          end
        end
        SDD_LOCAL: begin
          if (core_ack_in) begin
            state <= SDD_READY;
          end
        end
        SDD_READY: begin
          if (tgt_req_in && match) begin
            state <= SDD_IDLE;
          end
        end
        default: state <= SDD_IDLE;
      endcase
    end
  end

  // captured host access
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pend_write <= 1'b0;
      pend_addr <= 8'h00;
      pend_wdata <= 8'h00;
      pend_kind <= SDD_K_LOCAL;
      pend_ctl <= 1'b0;
      pend_ff <= 1'b0;
    end else if (take) begin
      pend_write <= tgt_write_in;
      pend_addr <= tgt_addr_in;
      pend_wdata <= tgt_wdata_in;
      pend_kind <= dec_kind;
      pend_ctl <= dec_ctl;
      pend_ff <= core_ff_in;
    end
  end

  // outstanding channel slots and peripheral cycle registers
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pend_mask <= 4'h0;
      cur_slot <= 2'h0;
      io_addr_out <= 32'h0000_0000;
      io_wdata_out <= 8'h00;
    end else if (ce_in) begin
      if (take) begin
        pend_mask <= dec_mask;
      end else if ((state == SDD_BUS_REQ && pci_gnt_in) ||
                   (state == SDD_PERIPH && io_ack_in)) begin
        pend_mask <= launch_mask;
        cur_slot <= launch_slot;
        io_addr_out <= launch_addr;
        io_wdata_out <= launch_wdata;
      end
    end
  end

  assign pci_req_out = (state == SDD_BUS_REQ) || (state == SDD_PERIPH);
  assign io_req_out = (state == SDD_PERIPH);
  assign io_write_out = pend_write;

  assign core_req_out = (state == SDD_DIRECT) || (state == SDD_LOCAL);
  assign core_write_out = pend_write;
  assign core_addr_out = pend_addr;
  assign core_wdata_out = pend_wdata;

  // read merge
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      merge_acc <= 8'h00;
      rdata <= 8'h00;
    end else if (ce_in) begin
      if (take) begin
        merge_acc <= 8'h00;
      end else if (state == SDD_PERIPH && io_ack_in && !pend_write) begin
        if (pend_kind == SDD_K_CMD) begin
          merge_acc <= merge_acc | (io_rdata_in & (`SDD_STATUS_MASK << cur_slot));
        end else begin
          merge_acc <= io_rdata_in;
        end
      end
      if (core_ack_in && state == SDD_DIRECT) begin
        rdata <= core_rdata_in;
      end else if (core_ack_in && state == SDD_LOCAL) begin
        if (pend_kind == SDD_K_CMD) begin
          rdata <= (core_rdata_in & ~({4'h0, slots_all} |
                    ({slots_all, 4'h0}))) | merge_acc;
        end else begin
          rdata <= merge_acc;
        end
      end
    end
  end
endmodule

// [sdd_monitor.sv]
// concurrent checks on the split-channel dma bridge ports
module sdd_monitor
  import sdd_pkg::*;
(
  input wire logic        clk_sys_in,
  input wire logic        rst_in,
  input wire logic        ce_in,
  input wire logic        tgt_req_in,
  input wire logic        tgt_done_out,
  input wire logic        tgt_retry_out,
  input wire logic        pci_req_out,
  input wire logic        pci_gnt_in,
  input wire logic        io_req_out,
  input wire logic        io_write_out,
  input wire logic [31:0] io_addr_out,
  input wire logic [7:0]  io_wdata_out,
  input wire logic        io_ack_in,
  input wire logic        core_req_out,
  input wire logic        core_ack_in,
  input wire logic [7:0]  core_addr_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  sequence granted_s; pci_req_out && pci_gnt_in; endsequence
  sequence io_wait_s; io_req_out && !io_ack_in; endsequence
  sequence mask_wr_s; io_req_out && io_write_out && io_addr_out[3:0] == 4'hF; endsequence
  one_answer_a: assert property (!(tgt_done_out && tgt_retry_out))
    else $error("done and retry together");
  io_top_zero_a: assert property (io_req_out |-> io_addr_out[31:16] == 16'h0000)
    else $error("peripheral address upper half not zero");
  io_index_a: assert property (io_req_out |-> io_addr_out[3:0] inside
    {4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h8, 4'h9, 4'hB, 4'hD, 4'hF})
    else $error("peripheral register index outside map");
  mask_bit_a: assert property (mask_wr_s |-> io_wdata_out[7:1] == 7'h00)
    else $error("mask write carries upper bits");
  io_granted_a: assert property (io_req_out |-> pci_gnt_in)
    else $error("io cycle without bus grant");
  grant_start_a: assert property (granted_s |-> ##[0:1] (io_req_out || core_req_out))
    else $error("grant not used");
  req_cause_a: assert property ($rose(pci_req_out) |-> $past(tgt_retry_out))
    else $error("bus request without retried access");
  busy_retry_a: assert property (pci_req_out && tgt_req_in && ce_in |-> tgt_retry_out)
    else $error("access not retried during sequence");
  io_hold_a: assert property (io_wait_s |=> io_req_out && $stable(io_addr_out))
    else $error("io request dropped or moved early");
  core_hold_a: assert property (core_req_out && !core_ack_in |=>
    core_req_out && $stable(core_addr_out))
    else $error("core request dropped or moved early");
endmodule
bind sdd_bridge sdd_monitor u_mon (.clk_sys_in, .rst_in, .ce_in, .tgt_req_in, .tgt_done_out,
  .tgt_retry_out, .pci_req_out, .pci_gnt_in, .io_req_out, .io_write_out, .io_addr_out,
  .io_wdata_out, .io_ack_in, .core_req_out, .core_ack_in, .core_addr_out);

// [sdd_partner.sv]
// far side: bus arbiter, split-channel peripherals and local dma core
module sdd_partner
  import sdd_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic [7:0]  rnd_in,
  input  wire logic        pci_req_in,
  output logic             pci_gnt_out,
  input  wire logic        io_req_in,
  input  wire logic        io_write_in,
  input  wire logic [31:0] io_addr_in,
  input  wire logic [7:0]  io_wdata_in,
  output logic      [7:0]  io_rdata_out,
  output logic             io_ack_out,
  input  wire logic        core_req_in,
  input  wire logic        core_write_in,
  input  wire logic [7:0]  core_addr_in,
  input  wire logic [7:0]  core_wdata_in,
  output logic      [7:0]  core_rdata_out,
  output logic             core_ack_out
);
  logic [7:0] per_mem [64];
  logic [7:0] core_mem [256];
  logic       io_go;
  logic       core_go;
  // random stalls on grant and on both acknowledges
  assign io_go   = io_req_in && !io_ack_out && rnd_in[1];
  assign core_go = core_req_in && !core_ack_out && rnd_in[2];
  always_ff @(posedge clk_sys_in) begin
    pci_gnt_out  <= !rst_in && (pci_req_in || io_req_in) && (pci_gnt_out || rnd_in[0]);
    io_ack_out   <= !rst_in && io_go;
    core_ack_out <= !rst_in && core_go;
    // data lines toggle while not carrying a value
    // status reads return the inverted command byte, so the merge sees distinct inputs
    io_rdata_out <= io_go && !io_write_in ?
                    per_mem[io_addr_in[5:0]] ^ {8{io_addr_in[3:0] == 4'h8}} : ~io_rdata_out;
    core_rdata_out <= core_go ? core_mem[core_addr_in] : ~core_rdata_out;
    if (io_go && io_write_in) begin
      per_mem[io_addr_in[5:0]] <= io_wdata_in;
    end
    if (core_go && core_write_in) begin
      core_mem[core_addr_in] <= core_wdata_in;
    end
  end
endmodule

// [test_distributed_dma_redirect.sv]
// self-checking bench for the split-channel dma redirect bridge
module test_distributed_dma_redirect;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_sys_in = 0, rst_in = 1, tgt_req_in = 0, tgt_write_in = 0, core_ff_in = 0;
  logic        cfg_wr_in = 0, cfg_rd_in = 0, tgt_done_out, tgt_retry_out, rt, ce_in = 1;
  logic        core_req_out, core_write_out, core_ack_in, pci_req_out, pci_gnt_in;
  logic        io_req_out, io_write_out, io_ack_in;
  logic [7:0]  tgt_addr_in = 0, tgt_wdata_in = 0, cfg_addr_in = 0, rnd = 0, rd, d;
  logic [7:0]  tgt_rdata_out, core_addr_out, core_wdata_out, core_rdata_in;
  logic [7:0]  io_wdata_out, io_rdata_in;
  logic [15:0] cfg_wdata_in = 0, cfg_rdata_out;
  logic [15:0] b_lo = 16'hABC6, b_hi = 16'h5A4F;
  logic [31:0] io_addr_out, seed = 32'hA2E7FE44;
  logic [40:0] io_q [$];
  int          fails = 0, check_count = 0, cyc = 0;

  sdd_bridge u_dut (.clk_sys_in, .rst_in, .ce_in, .tgt_req_in, .tgt_write_in,
    .tgt_addr_in, .tgt_wdata_in, .tgt_rdata_out, .tgt_done_out, .tgt_retry_out, .cfg_wr_in,
    .cfg_rd_in, .cfg_addr_in, .cfg_wdata_in, .cfg_rdata_out, .core_req_out, .core_write_out,
    .core_addr_out, .core_wdata_out, .core_rdata_in, .core_ack_in, .core_ff_in, .pci_req_out,
    .pci_gnt_in, .io_req_out, .io_write_out, .io_addr_out, .io_wdata_out, .io_rdata_in,
    .io_ack_in);
  sdd_partner u_far (.clk_sys_in, .rst_in, .rnd_in(rnd), .pci_req_in(pci_req_out),
    .pci_gnt_out(pci_gnt_in), .io_req_in(io_req_out), .io_write_in(io_write_out),
    .io_addr_in(io_addr_out), .io_wdata_in(io_wdata_out), .io_rdata_out(io_rdata_in),
    .io_ack_out(io_ack_in), .core_req_in(core_req_out), .core_write_in(core_write_out),
    .core_addr_in(core_addr_out), .core_wdata_in(core_wdata_out),
    .core_rdata_out(core_rdata_in), .core_ack_out(core_ack_in));

  always #2 clk_sys_in = ~clk_sys_in;

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  always @(negedge clk_sys_in) begin
    seed = xs(seed);
    rnd  = seed[7:0];
  end

  // log of finished peripheral cycles: write flag, address, data
  always @(posedge clk_sys_in) begin
    if (io_req_out && io_ack_in) begin
      io_q.push_back({io_write_out, io_addr_out, io_write_out ? io_wdata_out : io_rdata_in});
    end
    cyc++;
    if (cyc == 5000) begin
      fails++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [40:0] seen, input logic [40:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one host attempt: held until done or retry, dropped the next cycle
  task automatic acc(input logic w, input logic [7:0] a, dt, input logic f);
    @(negedge clk_sys_in);
    {tgt_req_in, tgt_write_in, tgt_addr_in, tgt_wdata_in, core_ff_in} = {1'b1, w, a, dt, f};
    for (int i = 0; i < 60; i++) begin
      #1;
      if (tgt_done_out === 1'b1 || tgt_retry_out === 1'b1) break;
      @(negedge clk_sys_in);
    end
    // no answer at all leaves rt unknown, so a hang never reads as a completion
    rt = tgt_done_out === 1'b1 ? 1'b0 : (tgt_retry_out === 1'b1 ? 1'b1 : 1'bx);
    rd = tgt_rdata_out;
    @(negedge clk_sys_in);
    tgt_req_in = 0;
  endtask

  task automatic rep(input logic w, input logic [7:0] a, dt, input logic f);
    for (int i = 0; i < 40 && rt === 1'b1; i++) acc(w, a, dt, f);
    chk(41'(rt), 41'h0);
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, dt, input logic f, er);
    acc(w, a, dt, f);
    chk(41'(rt), 41'(er));
    rep(w, a, dt, f);
  endtask

  task automatic eio(input logic w, h, input logic [1:0] c, input logic [3:0] x,
                     input logic [7:0] dv);
    logic [40:0] s;
    logic [15:0] b;
    b = h ? b_hi : b_lo;
    s = io_q.size() > 0 ? io_q.pop_front() : '1;
    chk(s, {w, 16'h0000, b[15:6], c, x, dv});
  endtask

  task automatic cfg(input logic [7:0] a, input logic [15:0] v, e);
    @(negedge clk_sys_in);
    {cfg_wr_in, cfg_addr_in, cfg_wdata_in} = {1'b1, a, v};
    @(negedge clk_sys_in);
    {cfg_wr_in, cfg_rd_in} = 2'b01;
    @(negedge clk_sys_in);
    cfg_rd_in = 0;
    #1 chk(41'(cfg_rdata_out), 41'(e));
  endtask

  initial begin
    repeat (10) @(negedge clk_sys_in);
    rst_in = 0;
    cfg(8'h92, b_lo, b_lo);
    cfg(8'h94, b_hi, b_hi);
    // disabled: neither the write nor the read register may move
    ce_in = 0;
    cfg(8'h92, 16'hFFFF, b_hi);
    ce_in = 1;
    d = rnd;
    xfer(1, 8'h06, d, 0, 0);
    acc(0, 8'h06, 8'h00, 0);
    chk(41'({rt, rd}), 41'({1'b0, d}));
    xfer(1, 8'hC0, rnd, 0, 0);
    chk(41'(io_q.size()), 41'h0);
    d = rnd;
    acc(1, 8'h02, d, 0);
    chk(41'(rt), 41'h1);
    acc(0, 8'h06, 8'h00, 0);
    chk(41'(rt), 41'h1);
    rep(1, 8'h02, d, 0);
    eio(1, 0, 1, 4'h0, d);
    d = rnd;
    xfer(1, 8'h03, d, 1, 1);
    eio(1, 0, 1, 4'h5, d);
    xfer(0, 8'h03, 8'h00, 1, 1);
    eio(0, 0, 1, 4'h5, d);
    chk(41'(rd), 41'(d));
    d = rnd;
    xfer(1, 8'h8B, d, 1, 1);
    eio(1, 1, 1, 4'h2, d);
    xfer(1, 8'h0A, 8'hF5, 0, 1);
    eio(1, 0, 1, 4'hF, 8'h01);
    xfer(1, 8'h0A, 8'h02, 0, 1);
    eio(1, 0, 2, 4'hF, 8'h00);
    xfer(1, 8'h0E, rnd, 0, 1);
    eio(1, 0, 1, 4'hF, 8'h00);
    eio(1, 0, 2, 4'hF, 8'h00);
    xfer(1, 8'h0B, 8'h42, 0, 1);
    eio(1, 0, 2, 4'hB, 8'h42);
    xfer(1, 8'hD6, 8'h01, 0, 1);
    eio(1, 1, 1, 4'hB, 8'h01);
    xfer(1, 8'h09, 8'h05, 0, 1);
    eio(1, 0, 1, 4'h9, 8'h05);
    d = rnd;
    xfer(1, 8'h08, d, 0, 1);
    eio(1, 0, 1, 4'h8, d);
    eio(1, 0, 2, 4'h8, d);
    xfer(1, 8'h0D, d, 0, 1);
    eio(1, 0, 1, 4'hD, d);
    eio(1, 0, 2, 4'hD, d);
    xfer(0, 8'h08, 8'h00, 0, 1);
    eio(0, 0, 1, 4'h8, ~d);
    eio(0, 0, 2, 4'h8, ~d);
    chk(41'(rd), 41'(d ^ 8'h66));
    xfer(1, 8'h0F, 8'h04, 0, 1);
    eio(1, 0, 1, 4'hF, 8'h00);
    eio(1, 0, 2, 4'hF, 8'h01);
    chk(41'(io_q.size()), 41'h0);
    complete_run();
  end
endmodule
